/* src/swire_pkg.sv */
// Shared constants, types and the CRC step for the single-wire scratchpad link.
package swire_pkg;
  localparam int CLK_MHZ = 100;
  // Device timing in microseconds and in clock cycles.
  localparam int DEV_RSTL_STD_US = 480;
  localparam int DEV_RSTL_OD_US = 48;
  localparam int DEV_PDH_STD_US = 20;
  localparam int DEV_PDH_OD_US = 3;
  localparam int DEV_PDL_STD_US = 100;
  localparam int DEV_PDL_OD_US = 10;
  localparam int DEV_BIT_STD_US = 30;
  localparam int DEV_BIT_OD_US = 3;
  localparam int DEV_RSTL_STD_CYC = DEV_RSTL_STD_US * CLK_MHZ;
  localparam int DEV_RSTL_OD_CYC = DEV_RSTL_OD_US * CLK_MHZ;
  localparam int DEV_PDH_STD_CYC = DEV_PDH_STD_US * CLK_MHZ;
  localparam int DEV_PDH_OD_CYC = DEV_PDH_OD_US * CLK_MHZ;
  localparam int DEV_PDL_STD_CYC = DEV_PDL_STD_US * CLK_MHZ;
  localparam int DEV_PDL_OD_CYC = DEV_PDL_OD_US * CLK_MHZ;
  localparam int DEV_BIT_STD_CYC = DEV_BIT_STD_US * CLK_MHZ;
  localparam int DEV_BIT_OD_CYC = DEV_BIT_OD_US * CLK_MHZ;
  // Host timing in microseconds and in clock cycles.
  localparam int HOST_RSTL_STD_US = 500;
  localparam int HOST_RSTL_OD_US = 60;
  localparam int HOST_RSTH_STD_US = 500;
  localparam int HOST_RSTH_OD_US = 50;
  localparam int HOST_MSP_STD_US = 70;
  localparam int HOST_MSP_OD_US = 8;
  localparam int HOST_LOW1_STD_US = 6;
  localparam int HOST_LOW1_OD_US = 1;
  localparam int HOST_LOW0_STD_US = 60;
  localparam int HOST_LOW0_OD_US = 8;
  localparam int HOST_SAMPLE_STD_US = 13;
  localparam int HOST_SAMPLE_OD_US = 2;
  localparam int HOST_SLOT_STD_US = 70;
  localparam int HOST_SLOT_OD_US = 11;
  localparam int HOST_RSTL_STD_CYC = HOST_RSTL_STD_US * CLK_MHZ;
  localparam int HOST_RSTL_OD_CYC = HOST_RSTL_OD_US * CLK_MHZ;
  localparam int HOST_RSTH_STD_CYC = HOST_RSTH_STD_US * CLK_MHZ;
  localparam int HOST_RSTH_OD_CYC = HOST_RSTH_OD_US * CLK_MHZ;
  localparam int HOST_MSP_STD_CYC = HOST_MSP_STD_US * CLK_MHZ;
  localparam int HOST_MSP_OD_CYC = HOST_MSP_OD_US * CLK_MHZ;
  localparam int HOST_LOW1_STD_CYC = HOST_LOW1_STD_US * CLK_MHZ;
  localparam int HOST_LOW1_OD_CYC = HOST_LOW1_OD_US * CLK_MHZ;
  localparam int HOST_LOW0_STD_CYC = HOST_LOW0_STD_US * CLK_MHZ;
  localparam int HOST_LOW0_OD_CYC = HOST_LOW0_OD_US * CLK_MHZ;
  localparam int HOST_SAMPLE_STD_CYC = HOST_SAMPLE_STD_US * CLK_MHZ;
  localparam int HOST_SAMPLE_OD_CYC = HOST_SAMPLE_OD_US * CLK_MHZ;
  localparam int HOST_SLOT_STD_CYC = HOST_SLOT_STD_US * CLK_MHZ;
  localparam int HOST_SLOT_OD_CYC = HOST_SLOT_OD_US * CLK_MHZ;
  // ROM and function command codes.
  localparam logic [7:0] ROM_SKIP = 8'hcc;
  localparam logic [7:0] ROM_OD_SKIP = 8'h3c;
  localparam logic [7:0] FN_WRITE_SP = 8'h0f;
  localparam logic [7:0] FN_READ_SP = 8'haa;
  localparam logic [7:0] FN_REFRESH_SP = 8'ha3;
  localparam logic [7:0] FN_COPY_SP = 8'h55;
  localparam logic [7:0] FN_LOAD_SECRET = 8'h5a;
  localparam logic [7:0] FN_COMPUTE_SECRET = 8'h33;
  localparam logic [7:0] FN_READ_MEM = 8'hf0;
  // Address map, status layout and readback byte positions.
  localparam logic [15:0] SECRET_FIRST = 16'h0080;
  localparam logic [15:0] SECRET_LAST = 16'h0087;
  localparam logic [7:0] ADDR_ALIGN_MASK = 8'hf8;
  localparam logic [7:0] ES_FIXED = 8'h5f;
  localparam int PF_BIT = 5;
  localparam int AA_BIT = 7;
  localparam logic PF_RESET = 1'b1;
  localparam logic [7:0] MASKED_BYTE = 8'hff;
  localparam logic [3:0] SP_LAST_IDX = 4'h7;
  localparam logic [3:0] WCRC_LAST_IDX = 4'h1;
  localparam logic [3:0] RTX_ES_IDX = 4'h2;
  localparam logic [3:0] RTX_SP_IDX = 4'h3;
  localparam logic [3:0] RTX_CRC_IDX = 4'hb;
  localparam logic [3:0] RTX_LAST_IDX = 4'hc;
  localparam logic [15:0] CRC_POLY_REV = 16'ha001;
  localparam logic [15:0] CRC_INIT = 16'h0000;

  typedef enum logic [3:0] {
    D_IDLE = 4'h0, D_ROM = 4'h1, D_FUNC = 4'h2, D_ADDR_LO = 4'h3,
    D_ADDR_HI = 4'h4, D_WDATA = 4'h5, D_WCRC = 4'h6, D_RTX = 4'h7,
    D_MEM = 4'h8, D_DONE = 4'h9
  } dev_state_t;
  typedef enum logic [1:0] {P_OFF = 2'h0, P_WAIT = 2'h1, P_DRIVE = 2'h2} pres_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'h0, H_RST_LOW = 2'h1, H_RST_HIGH = 2'h2, H_SLOT = 2'h3
  } host_state_t;
  typedef enum logic [1:0] {OP_RESET = 2'h0, OP_WRITE = 2'h1, OP_READ = 2'h2} host_op_t;

  // One CRC-16 step, reflected form, data taken least significant bit first.
  function automatic logic [15:0] crc16_bit(input logic [15:0] c, input logic b);
    logic fb;
    fb = c[0] ^ b;
    crc16_bit = (c >> 1) ^ (fb ? CRC_POLY_REV : 16'h0000);
  endfunction
endpackage

/* src/swire_if.sv */
// Open-drain single-wire link joining the host end and the device end.
`timescale 1ns/1ns
`default_nettype none
interface swire_if;
  logic host_dq_out;
  logic host_dq_oe;
  logic dev_dq_out;
  logic dev_dq_oe;
  logic line;
  // The wire idles high through the pull-up; any enabled low driver wins.
  assign line = ~((host_dq_oe & ~host_dq_out) | (dev_dq_oe & ~dev_dq_out));
  modport dev_end(input line, output dev_dq_out, output dev_dq_oe);
  modport host_end(input line, output host_dq_out, output host_dq_oe);
endinterface
`default_nettype wire

/* src/scratch_slave.sv */
// Device end: reset and presence, bit slots, scratchpad write and verify.
// Rules for the link, tagged where the code keeps them
// [RL1] Low three target address bits forced zero.
// [RL2] Ending offset bits always read one.
// [RL3] Status bits three, four, six read one.
// [RL4] Partial-byte flag set on incomplete final byte.
// [RL5] Partial-byte flag set after power loss.
// [RL6] Complete write clears partial-byte flag.
// [RL7] Copy sets accepted flag; writes clear it.
// [RL8] Status register read-only, reported in readback.
// [RL9] Master sends exactly eight data bytes.
// [RL10] Write followed by inverted CRC-16 offer.
// [RL11] Readback: address, status, then scratchpad.
// [RL12] Readback ends with inverted CRC over all.
// [RL13] Refresh updates flags exactly like write.
// [RL14] Master rewrites when either flag shows one; nothing here reads the flags back or repeats a write.
// [RL15] Verified scratchpad copied or loaded as secret.
// [RL16] Secret or protected reads return all ones.
// [RL17] Power-up in standard speed, overdrive cleared.
// [RL18] Suspended master leaves the line high.
// [RL19] Order: reset, ROM command, function, data.
// [RL20] Master reset pulse, device presence pulse.
// [RL21] ROM command is eight bits after presence.
// [RL22] Every slot starts at master falling edge.
// [RL23] All bytes travel least significant first.
// [RL24] CRC x16+x15+x2+1, zero start, inverted, low first.
`timescale 1ns/1ns
`default_nettype none
module scratch_slave
  import swire_pkg::*;
#(
  parameter int TRSTL_STD_CYC = DEV_RSTL_STD_CYC,
  parameter int TRSTL_OD_CYC = DEV_RSTL_OD_CYC,
  parameter int TPDL_STD_CYC = DEV_PDL_STD_CYC
)(
  input wire logic clk_in,
  input wire logic rstn_in,
  swire_if.dev_end link,
  output logic act_req_out,
  output logic [7:0] act_cmd_out,
  output logic [15:0] act_addr_out,
  output logic [63:0] sp_data_out,
  input wire logic act_done_in,
  output logic [15:0] mem_addr_out,
  input wire logic [7:0] mem_data_in,
  input wire logic mem_protected_in,
  output logic [7:0] status_out,
  output logic overdrive_out
);
  localparam logic [15:0] RSTL_STD = 16'(TRSTL_STD_CYC);
  localparam logic [15:0] RSTL_OD = 16'(TRSTL_OD_CYC);
  localparam logic [15:0] PDL_STD = 16'(TPDL_STD_CYC);
  localparam logic [15:0] PDL_OD = 16'(DEV_PDL_OD_CYC);
  localparam logic [15:0] PDH_STD = 16'(DEV_PDH_STD_CYC);
  localparam logic [15:0] PDH_OD = 16'(DEV_PDH_OD_CYC);
  localparam logic [15:0] BIT_STD = 16'(DEV_BIT_STD_CYC);
  localparam logic [15:0] BIT_OD = 16'(DEV_BIT_OD_CYC);

  dev_state_t state, next_state;
  pres_t pres, next_pres;
  logic prev, ext_low, next_ext_low, drive, next_drive;
  logic [15:0] low_cnt, next_low_cnt, pres_cnt, next_pres_cnt;
  logic [15:0] crc, next_crc, ta, next_ta, mem_addr, next_mem_addr;
  logic [2:0] bitcnt, next_bitcnt;
  logic [3:0] bytecnt, next_bytecnt;
  logic [7:0] shreg, next_shreg, cmd, next_cmd, tx_byte, es;
  logic [7:0] sp [8];
  logic [7:0] next_sp [8];
  logic pf, next_pf, aa, next_aa, od, next_od, act_req, next_act_req;
  logic fall, rise, tx_mode, crc_en;
  logic [15:0] bit_cyc, pdh_cyc, pdl_cyc, rstl_now;

  // Line edges and speed-dependent windows.
  assign fall = prev & ~link.line;
  assign rise = ~prev & link.line;
  assign bit_cyc = od ? BIT_OD : BIT_STD;
  assign pdh_cyc = od ? PDH_OD : PDH_STD;
  assign pdl_cyc = od ? PDL_OD : PDL_STD;
  assign rstl_now = od ? RSTL_OD : RSTL_STD;
  assign tx_mode = (state == D_WCRC) || (state == D_RTX) || (state == D_MEM);
  assign crc_en = (state == D_FUNC) || (state == D_ADDR_LO) ||
    (state == D_ADDR_HI) || (state == D_WDATA) ||
    ((state == D_RTX) && (bytecnt < RTX_CRC_IDX));

  // Status byte: fixed ones, partial-byte and accepted flags, read-only.
  assign es = ES_FIXED | (8'(pf) << PF_BIT) | (8'(aa) << AA_BIT); // [RL2] [RL3] [RL8]

  // Byte offered to the master at the start of each transmitted byte.
  always_comb
  begin
    tx_byte = MASKED_BYTE;
    case (state)
      D_WCRC:
        tx_byte = (bytecnt == 4'h0) ? ~crc[7:0] : ~crc[15:8]; // [RL10] [RL24]
      D_RTX:
        if (bytecnt == 4'h0)
          tx_byte = ta[7:0]; // [RL11]
        else if (bytecnt == 4'h1)
          tx_byte = ta[15:8];
        else if (bytecnt == RTX_ES_IDX)
          tx_byte = es; // [RL8]
        else if (bytecnt < RTX_CRC_IDX)
          tx_byte = sp[3'(bytecnt - RTX_SP_IDX)];
        else if (bytecnt == RTX_CRC_IDX)
          tx_byte = ~crc[7:0]; // [RL12] [RL24]
        else
          tx_byte = ~crc[15:8];
      D_MEM:
        if (mem_protected_in || ((mem_addr >= SECRET_FIRST) &&
            (mem_addr <= SECRET_LAST)))
          tx_byte = MASKED_BYTE; // [RL16]
        else
          tx_byte = mem_data_in;
      default:
        tx_byte = MASKED_BYTE;
    endcase
  end

  // Slot, presence and transaction sequencing.
  always_comb
  begin
    logic b;
    logic [7:0] cur;
    logic [7:0] byte_v;
    b = 1'b0;
    cur = shreg;
    byte_v = shreg;
    next_state = state;
    next_pres = pres;
    next_ext_low = ext_low;
    next_drive = drive;
    next_pres_cnt = pres_cnt;
    next_crc = crc;
    next_ta = ta;
    next_mem_addr = mem_addr;
    next_bitcnt = bitcnt;
    next_bytecnt = bytecnt;
    next_shreg = shreg;
    next_cmd = cmd;
    next_sp = sp;
    next_pf = pf;
    next_aa = aa;
    next_od = od;
    next_act_req = 1'b0;
    next_low_cnt = link.line ? 16'h0000 :
      ((low_cnt == 16'hffff) ? low_cnt : low_cnt + 16'h0001);
    if (pres == P_WAIT)
    begin
      next_pres_cnt = pres_cnt + 16'h0001;
      if (pres_cnt == pdh_cyc - 16'h0001)
      begin
        next_pres = P_DRIVE; // [RL20]
        next_drive = 1'b1;
        next_pres_cnt = 16'h0000;
      end
    end
    else if (pres == P_DRIVE)
    begin
      next_pres_cnt = pres_cnt + 16'h0001;
      if (pres_cnt == pdl_cyc - 16'h0001)
      begin
        next_pres = P_OFF;
        next_drive = 1'b0;
      end
    end
    else if (fall)
    begin
      next_ext_low = 1'b1; // [RL22]
      if (tx_mode)
      begin
        cur = (bitcnt == 3'h0) ? tx_byte : shreg;
        next_shreg = cur;
        next_drive = ~cur[0]; // [RL23]
      end
    end
    else if (drive && (low_cnt == bit_cyc))
      next_drive = 1'b0;
    else if (rise && ext_low)
    begin
      next_ext_low = 1'b0;
      if (low_cnt >= rstl_now)
      begin
        if (low_cnt >= RSTL_STD)
          next_od = 1'b0;
        next_state = D_ROM; // [RL19] [RL20]
        next_pres = P_WAIT;
        next_pres_cnt = 16'h0000;
        next_bitcnt = 3'h0;
        next_bytecnt = 4'h0;
      end
      else if ((state != D_IDLE) && (state != D_DONE))
      begin
        b = tx_mode ? shreg[0] : (low_cnt < bit_cyc); // [RL22]
        byte_v = {b, shreg[7:1]}; // [RL23]
        next_shreg = byte_v;
        next_bitcnt = bitcnt + 3'h1;
        if (crc_en)
          next_crc = crc16_bit(crc, b); // [RL24]
        if (state == D_WDATA)
          next_pf = (next_bitcnt != 3'h0); // [RL4] [RL6] [RL13]
        if (bitcnt == 3'h7)
        begin
          case (state)
            D_ROM:
            begin
              next_crc = CRC_INIT; // [RL21]
              next_state = D_DONE;
              if (byte_v == ROM_SKIP)
                next_state = D_FUNC;
              else if (byte_v == ROM_OD_SKIP)
              begin
                next_od = 1'b1;
                next_state = D_FUNC;
              end
            end
            D_FUNC:
            begin
              next_cmd = byte_v;
              next_bytecnt = 4'h0;
              case (byte_v)
                FN_WRITE_SP, FN_REFRESH_SP:
                begin
                  next_aa = 1'b0; // [RL7] [RL13]
                  next_state = D_ADDR_LO;
                end
                FN_READ_MEM:
                  next_state = D_ADDR_LO;
                FN_READ_SP:
                  next_state = D_RTX; // [RL11]
                FN_COPY_SP, FN_LOAD_SECRET, FN_COMPUTE_SECRET:
                begin
                  next_act_req = 1'b1; // [RL15]
                  next_state = D_DONE;
                end
                default:
                  next_state = D_DONE;
              endcase
            end
            D_ADDR_LO:
            begin
              next_ta[7:0] = byte_v & ADDR_ALIGN_MASK; // [RL1]
              next_mem_addr[7:0] = byte_v;
              next_state = D_ADDR_HI;
            end
            D_ADDR_HI:
            begin
              next_ta[15:8] = byte_v;
              next_mem_addr[15:8] = byte_v;
              next_state = (cmd == FN_READ_MEM) ? D_MEM : D_WDATA;
            end
            D_WDATA:
            begin
              next_sp[bytecnt[2:0]] = byte_v;
              next_bytecnt = bytecnt + 4'h1;
              if (bytecnt == SP_LAST_IDX)
              begin
                next_bytecnt = 4'h0;
                next_state = D_WCRC; // [RL10]
              end
            end
            D_WCRC:
            begin
              next_bytecnt = bytecnt + 4'h1;
              if (bytecnt == WCRC_LAST_IDX)
                next_state = D_DONE;
            end
            D_RTX:
            begin
              next_bytecnt = bytecnt + 4'h1;
              if (bytecnt == RTX_LAST_IDX)
                next_state = D_DONE; // [RL12]
            end
            D_MEM:
              next_mem_addr = mem_addr + 16'h0001;
            default:
              next_state = D_DONE;
          endcase
        end
      end
    end
    // A finished copy marks the scratchpad as accepted; this set wins.
    if (act_done_in && (cmd == FN_COPY_SP))
      next_aa = 1'b1; // [RL7] [RL15]
  end

  // State registers; power-up marks the scratchpad invalid at standard speed.
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state <= D_IDLE;
      pres <= P_OFF;
      prev <= 1'b1;
      ext_low <= 1'b0;
      drive <= 1'b0;
      low_cnt <= 16'h0000;
      pres_cnt <= 16'h0000;
      crc <= CRC_INIT;
      ta <= 16'h0000;
      mem_addr <= 16'h0000;
      bitcnt <= 3'h0;
      bytecnt <= 4'h0;
      shreg <= 8'h00;
      cmd <= 8'h00;
      for (int i = 0; i < 8; i++)
        sp[i] <= 8'h00;
      pf <= PF_RESET; // [RL5]
      aa <= 1'b0;
      od <= 1'b0; // [RL17]
      act_req <= 1'b0;
    end
    else
    begin
      state <= next_state;
      pres <= next_pres;
      prev <= link.line;
      ext_low <= next_ext_low;
      drive <= next_drive;
      low_cnt <= next_low_cnt;
      pres_cnt <= next_pres_cnt;
      crc <= next_crc;
      ta <= next_ta;
      mem_addr <= next_mem_addr;
      bitcnt <= next_bitcnt;
      bytecnt <= next_bytecnt;
      shreg <= next_shreg;
      cmd <= next_cmd;
      sp <= next_sp;
      pf <= next_pf;
      aa <= next_aa;
      od <= next_od;
      act_req <= next_act_req;
    end
  end

  // Scratchpad image for the copy and secret engines, byte 0 lowest.
  generate
    for (genvar g = 0; g < 8; g++)
    begin : g_sp
      assign sp_data_out[8*g +: 8] = sp[g];
    end
  endgenerate

  // Open-drain drive and user-side outputs.
  assign link.dev_dq_out = 1'b0;
  assign link.dev_dq_oe = drive;
  assign act_req_out = act_req;
  assign act_cmd_out = cmd;
  assign act_addr_out = ta;
  assign mem_addr_out = mem_addr;
  assign status_out = es;
  assign overdrive_out = od;
endmodule
`default_nettype wire

/* src/swire_master.sv */
// Host end: reset with presence check and byte-wide write and read slots.
`timescale 1ns/1ns
`default_nettype none
module swire_master
  import swire_pkg::*;
#(
  parameter int TRSTL_STD_CYC = HOST_RSTL_STD_CYC,
  parameter int TRSTL_OD_CYC = HOST_RSTL_OD_CYC,
  parameter int TRSTH_STD_CYC = HOST_RSTH_STD_CYC,
  parameter int TRSTH_OD_CYC = HOST_RSTH_OD_CYC,
  parameter int TMSP_STD_CYC = HOST_MSP_STD_CYC,
  parameter int TSLOT_STD_CYC = HOST_SLOT_STD_CYC
)(
  input wire logic clk_in,
  input wire logic rstn_in,
  swire_if.host_end link,
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_op_in,
  input wire logic [7:0] cmd_data_in,
  input wire logic od_in,
  output logic cmd_ready_out,
  output logic done_out,
  output logic [7:0] rdata_out,
  output logic presence_out
);
  host_state_t state, next_state;
  logic [15:0] cnt, next_cnt, rstl, rsth, msp, slot, sample;
  logic [2:0] bitcnt, next_bitcnt;
  logic [7:0] sh, next_sh, rdata, next_rdata;
  logic [1:0] op, next_op;
  logic od, next_od, rx, next_rx, pull, next_pull;
  logic done, next_done, pres, next_pres;

  // Speed-dependent windows, chosen per command.
  assign rstl = od ? 16'(TRSTL_OD_CYC) : 16'(TRSTL_STD_CYC);
  assign rsth = od ? 16'(TRSTH_OD_CYC) : 16'(TRSTH_STD_CYC);
  assign msp = od ? 16'(HOST_MSP_OD_CYC) : 16'(TMSP_STD_CYC);
  assign slot = od ? 16'(HOST_SLOT_OD_CYC) : 16'(TSLOT_STD_CYC);
  assign sample = od ? 16'(HOST_SAMPLE_OD_CYC) : 16'(HOST_SAMPLE_STD_CYC);

  // Low time that opens a slot: long for a written zero, short otherwise.
  function automatic logic [15:0] low_len(input logic [1:0] o,
    input logic b, input logic f);
    if ((o == OP_WRITE) && !b)
      low_len = f ? 16'(HOST_LOW0_OD_CYC) : 16'(HOST_LOW0_STD_CYC);
    else
      low_len = f ? 16'(HOST_LOW1_OD_CYC) : 16'(HOST_LOW1_STD_CYC);
  endfunction

  // Command sequencing and slot timing.
  always_comb
  begin
    next_state = state;
    next_cnt = cnt + 16'h0001;
    next_bitcnt = bitcnt;
    next_sh = sh;
    next_rdata = rdata;
    next_op = op;
    next_od = od;
    next_rx = rx;
    next_pres = pres;
    next_done = 1'b0;
    case (state)
      H_IDLE:
      begin
        next_cnt = 16'h0000;
        if (cmd_valid_in)
        begin
          next_op = cmd_op_in;
          next_sh = cmd_data_in;
          next_od = od_in;
          next_bitcnt = 3'h0;
          next_state = (cmd_op_in == OP_RESET) ? H_RST_LOW : H_SLOT; // [RL19]
        end
      end
      H_RST_LOW:
        if (cnt == rstl - 16'h0001)
        begin
          next_cnt = 16'h0000;
          next_state = H_RST_HIGH; // [RL20]
        end
      H_RST_HIGH:
      begin
        if (cnt == msp)
          next_pres = ~link.line; // [RL20]
        if (cnt == rsth - 16'h0001)
        begin
          next_done = 1'b1;
          next_state = H_IDLE;
        end
      end
      H_SLOT:
      begin
        if (cnt == sample)
          next_rx = link.line;
        if (cnt == slot - 16'h0001)
        begin
          next_cnt = 16'h0000;
          next_sh = {(op == OP_READ) ? rx : sh[0], sh[7:1]}; // [RL23]
          next_bitcnt = bitcnt + 3'h1;
          if (bitcnt == 3'h7)
          begin
            next_rdata = next_sh;
            next_done = 1'b1;
            next_state = H_IDLE;
          end
        end
      end
      default:
        next_state = H_IDLE;
    endcase
    // Each slot opens with a falling edge; the line is released when idle.
    next_pull = (next_state == H_RST_LOW) || ((next_state == H_SLOT) &&
      (next_cnt < low_len(next_op, next_sh[0], next_od))); // [RL22] [RL18]
  end

  // State registers.
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state <= H_IDLE;
      cnt <= 16'h0000;
      bitcnt <= 3'h0;
      sh <= 8'h00;
      rdata <= 8'h00;
      op <= 2'h0;
      od <= 1'b0;
      rx <= 1'b1;
      pull <= 1'b0;
      done <= 1'b0;
      pres <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      bitcnt <= next_bitcnt;
      sh <= next_sh;
      rdata <= next_rdata;
      op <= next_op;
      od <= next_od;
      rx <= next_rx;
      pull <= next_pull;
      done <= next_done;
      pres <= next_pres;
    end
  end

  assign link.host_dq_out = 1'b0;
  assign link.host_dq_oe = pull;
  assign cmd_ready_out = (state == H_IDLE);
  assign done_out = done;
  assign rdata_out = rdata;
  assign presence_out = pres;
endmodule
`default_nettype wire

/* verif/swire_chk.sv */
// Wire-level checks for the single-wire link between both ends.
`timescale 1ns/1ns
`default_nettype none
module swire_chk (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic host_dq_out,
  input wire logic host_dq_oe,
  input wire logic dev_dq_out,
  input wire logic dev_dq_oe,
  input wire logic line
);
  logic [15:0] hc, gap, dc, hi, pw;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // Saturating step, so long idle stretches never wrap to a small count.
  function automatic logic [15:0] sat(input logic [15:0] x);
    sat = (x == 16'hffff) ? x : x + 16'h1;
  endfunction
  // Run lengths of host low and release, device low, line high, presence wait.
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      hc <= 16'h0;
      gap <= 16'hffff;
      dc <= 16'h0;
      hi <= 16'h0;
      pw <= 16'h0;
    end
    else
    begin
      hc <= host_dq_oe ? sat(hc) : 16'h0;
      gap <= host_dq_oe ? 16'h0 : sat(gap);
      dc <= dev_dq_oe ? sat(dc) : 16'h0;
      hi <= line ? sat(hi) : 16'h0;
      pw <= dev_dq_oe ? 16'h0 : (!host_dq_oe && hc >= 16'd8000) ? 16'h1 :
        (pw == 16'h0) ? pw : sat(pw);
    end
  a_dev_open_drain: assert property (dev_dq_oe |-> !dev_dq_out)
    else $error("device drives the line high");
  a_host_open_drain: assert property (host_dq_oe |-> !host_dq_out)
    else $error("host drives the line high");
  a_idle_high: assert property (!host_dq_oe && !dev_dq_oe |-> line)
    else $error("released line is not high");
  a_dev_no_start: assert property ($rose(dev_dq_oe) |->
    $past(host_dq_oe) || hi >= 16'd250)
    else $error("device started a low outside a slot or presence");
  a_presence_due: assert property (pw <= 16'd2500)
    else $error("no presence after a reset pulse");
  a_dev_hold_max: assert property (dc <= 16'd10001)
    else $error("device held the line low too long");
  a_host_recovery: assert property ($rose(host_dq_oe) |-> gap >= 16'd200)
    else $error("host slot started without recovery");
  a_host_low_len: assert property ($fell(host_dq_oe) |-> hc inside
    {[95:105], [595:605], [795:805], [2995:3005], [5995:6005], [8995:9005]})
    else $error("host low pulse of unexpected length");
  c_presence: cover property ($rose(dev_dq_oe) && !host_dq_oe);
  c_read_zero: cover property ($rose(dev_dq_oe) && host_dq_oe);
  c_od_reset: cover property ($fell(host_dq_oe) && hc inside {[2995:3005]});
endmodule
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench joining the host end and the device end.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import swire_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [7:0] cmd_data = 8'h00;
  logic od = 1'b0;
  logic act_done = 1'b0;
  logic prot = 1'b0;
  logic ready, done, pres, act_req, ovd;
  logic [7:0] rdata, status, act_cmd, ta_lo, ta_hi;
  logic [15:0] act_addr, lf, crc;
  logic [63:0] sp;
  logic [7:0] e [11];
  int bad_count = 0;
  int num_checks = 0;
  int req_n = 0;
  swire_if link_if ();
  scratch_slave #(.TRSTL_STD_CYC(8000), .TRSTL_OD_CYC(2000))
    scratch_slave_inst (.clk_in(clk_in),
    .rstn_in(rstn_in), .link(link_if), .act_req_out(act_req),
    .act_cmd_out(act_cmd), .act_addr_out(act_addr), .sp_data_out(sp),
    .act_done_in(act_done), .mem_addr_out(), .mem_data_in(lf[7:0]),
    .mem_protected_in(prot), .status_out(status), .overdrive_out(ovd));
  swire_master #(.TRSTL_STD_CYC(9000), .TRSTL_OD_CYC(3000),
    .TRSTH_STD_CYC(13000)) swire_master_inst (.clk_in(clk_in),
    .rstn_in(rstn_in), .link(link_if), .cmd_valid_in(cmd_valid),
    .cmd_op_in(cmd_op), .cmd_data_in(cmd_data), .od_in(od),
    .cmd_ready_out(ready), .done_out(done), .rdata_out(rdata),
    .presence_out(pres));
  swire_chk swire_chk_inst (.clk_in(clk_in), .rstn_in(rstn_in),
    .host_dq_out(link_if.host_dq_out), .host_dq_oe(link_if.host_dq_oe),
    .dev_dq_out(link_if.dev_dq_out), .dev_dq_oe(link_if.dev_dq_oe),
    .line(link_if.line));
  // The clock toggles every half period of 5 ns.
  always #5 clk_in = ~clk_in;
  // Copy requests are counted as they pulse.
  always @(posedge clk_in)
    if (act_req === 1'b1)
      req_n++;
  // Random source, a 16-bit shift register.
  function automatic logic [15:0] nxt(input logic [15:0] s);
    nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Reflected CRC-16 over one byte, least significant bit first.
  function automatic logic [15:0] crc8(input logic [15:0] c,
    input logic [7:0] b);
    logic f;
    for (int i = 0; i < 8; i++)
    begin
      f = c[0] ^ b[i];
      c = (c >> 1) ^ (f ? 16'ha001 : 16'h0000);
    end
    crc8 = c;
  endfunction
  task automatic chk(input string n, input logic [63:0] x, input logic [63:0] s);
    num_checks++;
    if (x !== s)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // One host command, held for one take edge, then a bounded wait for done.
  task automatic op(input logic [1:0] o, input logic [7:0] b);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 100)
    begin
      @(negedge clk_in);
      n++;
    end
    cmd_op = o;
    cmd_data = b;
    cmd_valid = 1'b1;
    @(negedge clk_in);
    cmd_valid = 1'b0;
    n = (n >= 100) ? 200000 : 0;
    while (done !== 1'b1 && n < 200000)
    begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 200000)
    begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] x);
    op(OP_READ, 8'h00);
    chk(n, x, rdata);
  endtask
  task automatic start(input logic [7:0] f);
    op(OP_RESET, 8'h00);
    op(OP_WRITE, ROM_SKIP);
    op(OP_WRITE, f);
  endtask
  // Main sequence: power-up, overdrive, write, readback and copy.
  initial
  begin
    lf = 16'h693a;
    repeat (16) @(negedge clk_in);
    rstn_in = 1'b1;
    chk("status", 8'h7f, status);
    chk("overdrive", 1'b0, ovd);
    op(OP_RESET, 8'h00);
    chk("presence", 1'b1, pres);
    op(OP_WRITE, ROM_OD_SKIP);
    chk("overdrive", 1'b1, ovd);
    od = 1'b1;
    $display("test power_up done");
    start(FN_WRITE_SP);
    lf = nxt(lf);
    ta_lo = lf[7:0] | 8'h05;
    ta_hi = lf[15:8];
    crc = crc8(crc8(crc8(16'h0000, FN_WRITE_SP), ta_lo), ta_hi);
    op(OP_WRITE, ta_lo);
    op(OP_WRITE, ta_hi);
    for (int i = 0; i < 8; i++)
    begin
      lf = nxt(lf);
      e[i+3] = (i == 0) ? 8'h01 : lf[7:0];
      crc = crc8(crc, e[i+3]);
      op(OP_WRITE, e[i+3]);
    end
    rchk("wcrc_lo", ~crc[7:0]);
    rchk("wcrc_hi", ~crc[15:8]);
    chk("addr", {ta_hi, ta_lo & 8'hf8}, act_addr);
    chk("status", 8'h5f, status);
    for (int i = 0; i < 8; i++)
      chk("scratch", e[i+3], sp[8*i+:8]);
    $display("test write done");
    start(FN_READ_SP);
    crc = crc8(16'h0000, FN_READ_SP);
    e[0] = ta_lo & 8'hf8;
    e[1] = ta_hi;
    e[2] = 8'h5f;
    for (int i = 0; i < 11; i++)
    begin
      rchk("readback", e[i]);
      crc = crc8(crc, e[i]);
    end
    rchk("rcrc_lo", ~crc[7:0]);
    rchk("rcrc_hi", ~crc[15:8]);
    $display("test readback done");
    start(FN_COPY_SP);
    chk("act_cmd", FN_COPY_SP, act_cmd);
    chk("act_req", 1, req_n);
    act_done = 1'b1;
    @(negedge clk_in);
    act_done = 1'b0;
    @(negedge clk_in);
    chk("status", 8'hdf, status);
    start(FN_READ_MEM);
    op(OP_WRITE, 8'h7e);
    op(OP_WRITE, 8'h00);
    rchk("memory", lf[7:0]);
    prot = 1'b1;
    rchk("protected", 8'hff);
    prot = 1'b0;
    rchk("secret", 8'hff);
    $display("test copy and masking done");
    print_verdict();
  end
endmodule
`default_nettype wire
